// File: logic/gpb_defines.vh
// register offsets, field layout and reset values for the general i/o port bank
// assumes a classic wishbone slave with 32-bit data and byte addressing
// How it works
// (R1) there are up to seven ports, a through g, each sixteen pins wide.
// (R2) parameters let a variant leave out whole ports and single pin positions.
// (R3) each port has a direction, an output latch, a pin read-back and an open-drain select register.
// (R4) a direction bit of 0 makes the pin an output and 1 makes it an input.
// (R5) writing the latch sets the level driven on output pins, and input pins keep but do not drive it.
// (R6) reading the latch returns the last value written to it, not the pins.
// (R7) reading the read-back register returns the present level of every pin of the port.
// (R8) writing the read-back register acts exactly like writing the latch of that port.
// (R9) an open-drain bit of 0 gives a push-pull driver and 1 gives an open-drain driver.
// (R10) every pin is set up on its own, apart from the other pins of its port.
// (R11) a pin claimed by an alternate serial function is neither driven nor steered by the port.
// (R12) the two buttons on port a bits 6 and 7 read high when pressed once software makes them inputs.
// (R13) the four lamps on port b bits 10 to 13 light when their latch bit is 1 and the pin is a push-pull output.
// (R14) after reset every pin is an input, push-pull, with its latch at zero, so nothing drives.
// (R15) an open-drain pin pulls low for a latch bit of 0 and floats for a latch bit of 1.
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH

`define GPB_NUM_PORTS      7
`define GPB_PORT_WIDTH     16
`define GPB_PORT_STRIDE    8'h10
`define GPB_OFS_DIRECTION  2'h0
`define GPB_OFS_LATCH      2'h1
`define GPB_OFS_READBACK   2'h2
`define GPB_OFS_OPEN_DRAIN 2'h3
`define GPB_RST_DIRECTION  16'hFFFF
`define GPB_RST_LATCH      16'h0000
`define GPB_RST_OPEN_DRAIN 16'h0000
`define GPB_ADDR_WIDTH     8
`define GPB_WORD_LSB       2
`define GPB_REG_SEL_LSB    2
`define GPB_PORT_SEL_LSB   4

`endif

// File: logic/gpb_port_bank.v
// general i/o port bank: seven 16-bit ports behind a classic wishbone slave
// assumes pin inputs are synchronous to sys_clk; the pad ring resolves each pin from out and oe
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "gpb_defines.vh"

module gpb_port_bank #(
  parameter [6:0]   PORT_PRESENT = 7'h7F,     // one bit per port a..g
  parameter [111:0] BIT_PRESENT  = {7{16'hFFFF}}  // 16 bits per port, port a lowest
) (
  input  wire          sys_clk,      // 50 MHz clock
  input  wire          reset_n,      // asynchronous reset, active low
  input  wire [7:0]    wb_adr_i,     // byte address
  input  wire [31:0]   wb_dat_i,     // write data
  input  wire [3:0]    wb_sel_i,     // byte enables
  input  wire          wb_we_i,      // write strobe
  input  wire          wb_cyc_i,     // bus cycle
  input  wire          wb_stb_i,     // strobe
  output reg  [31:0]   wb_dat_o,     // read data
  output reg           wb_ack_o,     // acknowledge
  input  wire [111:0]  pin_in,       // pin levels, port a in bits 15:0
  output wire [111:0]  pin_out,      // pin output level
  output wire [111:0]  pin_oe,       // pin output enable, high while driving
  input  wire [111:0]  alt_claim     // pin taken by an alternate serial function
);

  localparam NP   = `GPB_NUM_PORTS;
  localparam W    = `GPB_PORT_WIDTH;
  localparam NB   = NP * W;
  localparam DW   = 32;
  localparam LANE = 8;

  // reset and register codes, sized to the fields they meet
  localparam [W-1:0] RST_DIR = `GPB_RST_DIRECTION;
  localparam [W-1:0] RST_LAT = `GPB_RST_LATCH;
  localparam [W-1:0] RST_ODC = `GPB_RST_OPEN_DRAIN;
  localparam [1:0]   REG_DIR = `GPB_OFS_DIRECTION;
  localparam [1:0]   REG_LAT = `GPB_OFS_LATCH;
  localparam [1:0]   REG_PIN = `GPB_OFS_READBACK;
  localparam [1:0]   REG_ODC = `GPB_OFS_OPEN_DRAIN;

  // port map padded to eight so an out-of-range port number reads as absent
  localparam [7:0] PORT_MAP = {1'b0, PORT_PRESENT};

  // flat per-pin state, port p in bits 16p+15:16p
  wire [NB-1:0]  dir_bits;
  wire [NB-1:0]  lat_bits;
  wire [NB-1:0]  odc_bits;
  wire [NB-1:0]  keep_bits;
  wire [NB-1:0]  pin_seen;
  wire [NB-1:0]  next_out_bits;
  wire [NB-1:0]  next_oe_bits;
  wire [NB-1:0]  out_bits;
  wire [NB-1:0]  oe_bits;

  // bus decode
  wire [2:0]     port_sel;
  wire [1:0]     reg_sel;
  wire           adr_high;
  wire           hit;
  wire           req;
  wire           wr;
  wire           rd;
  wire [W-1:0]   wmask;
  wire [W-1:0]   wdata;
  wire           wr_dir;
  wire           wr_lat;
  wire           wr_odc;
  wire [NP-1:0]  port_hit;
  wire [NP-1:0]  port_dir_wr;
  wire [NP-1:0]  port_lat_wr;
  wire [NP-1:0]  port_odc_wr;

  // read side
  reg  [W-1:0]   dir_word;
  reg  [W-1:0]   lat_word;
  reg  [W-1:0]   odc_word;
  reg  [W-1:0]   pin_word;
  reg  [W-1:0]   next_rdata;

  assign port_sel = wb_adr_i[`GPB_PORT_SEL_LSB+2:`GPB_PORT_SEL_LSB];
  assign reg_sel  = wb_adr_i[`GPB_REG_SEL_LSB+1:`GPB_REG_SEL_LSB];
  assign adr_high = wb_adr_i[`GPB_ADDR_WIDTH-1];
  assign hit      = PORT_MAP[port_sel] && !adr_high;
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr       = req && wb_we_i && hit;
  assign rd       = req && !wb_we_i && hit;

  // only the low two lanes hold data; upper lanes are ignored on write
  assign wmask = {{LANE{wb_sel_i[1]}}, {LANE{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[W-1:0];

  // the read-back offset writes the latch, so both offsets share one strobe
  assign wr_dir = wr && (reg_sel == REG_DIR);  // see (R3)
  assign wr_lat = wr && ((reg_sel == REG_LAT) || (reg_sel == REG_PIN));  // see (R5) see (R8)
  assign wr_odc = wr && (reg_sel == REG_ODC);

  // bus answer: ack one cycle after the request, dropped the cycle after
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // per-port strobes and the mask of pins that exist
  genvar p;
  generate
    for (p = 0; p < NP; p = p + 1) begin : g_port
      assign port_hit[p]         = (port_sel == p);
      assign port_dir_wr[p]      = wr_dir && port_hit[p];
      assign port_lat_wr[p]      = wr_lat && port_hit[p];
      assign port_odc_wr[p]      = wr_odc && port_hit[p];
      assign keep_bits[p*W +: W] = PORT_PRESENT[p] ? BIT_PRESENT[p*W +: W] : {W{1'b0}};  // see (R1) see (R2)
    end
  endgenerate

  // pins read raw whatever their direction, masked to present bits
  assign pin_seen = pin_in & keep_bits;  // see (R7)

  // one cell per pin; absent pins get no flip-flops and read as zero
  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_pin
      if (PORT_PRESENT[b / W] && BIT_PRESENT[b]) begin : g_on
        reg  dir_q;
        reg  lat_q;
        reg  odc_q;
        reg  out_q;
        reg  oe_q;
        wire byte_on;
        wire wbit;
        wire dir_load;
        wire lat_load;
        wire odc_load;
        wire next_dir;
        wire next_lat;
        wire next_odc;

        assign byte_on  = wmask[b % W];
        assign wbit     = wdata[b % W];
        assign dir_load = port_dir_wr[b / W] && byte_on;
        assign lat_load = port_lat_wr[b / W] && byte_on;
        assign odc_load = port_odc_wr[b / W] && byte_on;

        // each pin is loaded on its own, apart from the rest of its port
        assign next_dir = dir_load ? wbit : dir_q;  // see (R4) see (R10)
        assign next_lat = lat_load ? wbit : lat_q;  // see (R5) see (R8)
        assign next_odc = odc_load ? wbit : odc_q;  // see (R9)

        // direction resets to input so no pin drives before software sets it up
        always @(posedge sys_clk or negedge reset_n) begin
          if (!reset_n) begin
            dir_q <= RST_DIR[b % W];  // see (R14)
          end else begin
            dir_q <= next_dir;
          end
        end

        // latch keeps its value while the pin is an input
        always @(posedge sys_clk or negedge reset_n) begin
          if (!reset_n) begin
            lat_q <= RST_LAT[b % W];  // see (R14)
          end else begin
            lat_q <= next_lat;
          end
        end

        always @(posedge sys_clk or negedge reset_n) begin
          if (!reset_n) begin
            odc_q <= RST_ODC[b % W];  // see (R14)
          end else begin
            odc_q <= next_odc;
          end
        end

        // open drain never drives high: the level is low and only oe carries the latch
        assign next_out_bits[b] = lat_q & ~odc_q;  // see (R9) see (R15)
        assign next_oe_bits[b]  = ~dir_q & ~alt_claim[b] & ~(odc_q & lat_q);  // see (R4) see (R11) see (R15)

        // registered so every pad output comes straight from a flip-flop
        always @(posedge sys_clk or negedge reset_n) begin
          if (!reset_n) begin
            out_q <= 1'b0;
          end else begin
            out_q <= next_out_bits[b];
          end
        end

        always @(posedge sys_clk or negedge reset_n) begin
          if (!reset_n) begin
            oe_q <= 1'b0;
          end else begin
            oe_q <= next_oe_bits[b];
          end
        end

        assign dir_bits[b] = dir_q;
        assign lat_bits[b] = lat_q;
        assign odc_bits[b] = odc_q;
        assign out_bits[b] = out_q;
        assign oe_bits[b]  = oe_q;
      end else begin : g_off
        assign dir_bits[b]      = 1'b0;
        assign lat_bits[b]      = 1'b0;
        assign odc_bits[b]      = 1'b0;
        assign next_out_bits[b] = 1'b0;
        assign next_oe_bits[b]  = 1'b0;
        assign out_bits[b]      = 1'b0;
        assign oe_bits[b]       = 1'b0;
      end
    end
  endgenerate

  assign pin_out = out_bits;
  assign pin_oe  = oe_bits;

  // port select for the read path; constant slices keep every index in range
  always @* begin
    dir_word = {W{1'b0}};
    case (port_sel)
      3'h0: begin
        dir_word = dir_bits[0*W +: W];
      end
      3'h1: begin
        dir_word = dir_bits[1*W +: W];
      end
      3'h2: begin
        dir_word = dir_bits[2*W +: W];
      end
      3'h3: begin
        dir_word = dir_bits[3*W +: W];
      end
      3'h4: begin
        dir_word = dir_bits[4*W +: W];
      end
      3'h5: begin
        dir_word = dir_bits[5*W +: W];
      end
      3'h6: begin
        dir_word = dir_bits[6*W +: W];
      end
      default: dir_word = {W{1'b0}};
    endcase
  end

  always @* begin
    lat_word = {W{1'b0}};
    case (port_sel)
      3'h0: begin
        lat_word = lat_bits[0*W +: W];
      end
      3'h1: begin
        lat_word = lat_bits[1*W +: W];
      end
      3'h2: begin
        lat_word = lat_bits[2*W +: W];
      end
      3'h3: begin
        lat_word = lat_bits[3*W +: W];
      end
      3'h4: begin
        lat_word = lat_bits[4*W +: W];
      end
      3'h5: begin
        lat_word = lat_bits[5*W +: W];
      end
      3'h6: begin
        lat_word = lat_bits[6*W +: W];
      end
      default: lat_word = {W{1'b0}};
    endcase
  end

  always @* begin
    odc_word = {W{1'b0}};
    case (port_sel)
      3'h0: begin
        odc_word = odc_bits[0*W +: W];
      end
      3'h1: begin
        odc_word = odc_bits[1*W +: W];
      end
      3'h2: begin
        odc_word = odc_bits[2*W +: W];
      end
      3'h3: begin
        odc_word = odc_bits[3*W +: W];
      end
      3'h4: begin
        odc_word = odc_bits[4*W +: W];
      end
      3'h5: begin
        odc_word = odc_bits[5*W +: W];
      end
      3'h6: begin
        odc_word = odc_bits[6*W +: W];
      end
      default: odc_word = {W{1'b0}};
    endcase
  end

  always @* begin
    pin_word = {W{1'b0}};
    case (port_sel)
      3'h0: begin
        pin_word = pin_seen[0*W +: W];
      end
      3'h1: begin
        pin_word = pin_seen[1*W +: W];
      end
      3'h2: begin
        pin_word = pin_seen[2*W +: W];
      end
      3'h3: begin
        pin_word = pin_seen[3*W +: W];
      end
      3'h4: begin
        pin_word = pin_seen[4*W +: W];
      end
      3'h5: begin
        pin_word = pin_seen[5*W +: W];
      end
      3'h6: begin
        pin_word = pin_seen[6*W +: W];
      end
      default: pin_word = {W{1'b0}};
    endcase
  end

  // register select; writes and unmapped reads give zero
  always @* begin
    next_rdata = {W{1'b0}};
    if (rd) begin
      case (reg_sel)
        REG_DIR: begin
          next_rdata = dir_word;
        end
        REG_LAT: begin
          next_rdata = lat_word;  // see (R6)
        end
        REG_PIN: begin
          next_rdata = pin_word;  // see (R7)
        end
        REG_ODC: begin
          next_rdata = odc_word;
        end
        default: begin
          next_rdata = {W{1'b0}};
        end
      endcase
    end
  end

  // read data registered with the ack and held until the next request
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (req) begin
      wb_dat_o <= {{(DW-W){1'b0}}, next_rdata};
    end
  end

endmodule

// File: tb/gpb_board.sv
// board side: two buttons on port a, four lamps on port b
// released lines read high, idle buttons read low
`timescale 1ns/100ps
module gpb_board (
  input  wire [111:0] pin_out, pin_oe, // pad drive
  input  wire [1:0]   btn,             // pressed
  output wire [111:0] pin_in,          // wire level
  output wire [3:0]   lamp             // lit
);
  wire [111:0] idle = {{13{8'hFF}}, btn, 6'h3F};
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & idle);
  assign lamp = pin_oe[29:26] & pin_out[29:26];
endmodule

// File: tb/gpb_checker.sv
// bus handshake and pin timing checks for the port bank
// bound into gpb_port_bank, sees its ports only
`timescale 1ns/100ps
module gpb_checker (
  input wire         sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_ack_o, // clock, reset, bus
  input wire [31:0]  wb_dat_o,                                      // read data
  input wire [111:0] pin_out, pin_oe, alt_claim                     // pins
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_taken: assert property (req |=> wb_ack_o) else $error("no ack");
  a_ack_idle: assert property (!req |=> !wb_ack_o) else $error("stray ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper");
  a_dat_hold: assert property (!$past(req) |-> $stable(wb_dat_o)) else $error("data moved");
  a_claim_off: assert property ((pin_oe & $past(alt_claim)) == 112'h0) else $error("claimed");
  a_oe_cause: assert property ($changed(pin_oe) |-> $past(wb_ack_o) ||
    $past(alt_claim) != $past(alt_claim, 2)) else $error("oe moved");
  a_out_cause: assert property ($changed(pin_out) |-> $past(wb_ack_o)) else $error("out moved");
  c_access: cover property (req ##1 wb_ack_o);
  c_sink: cover property (|(pin_oe & ~pin_out));
  c_drive: cover property ($rose(|pin_oe));
endmodule
bind gpb_port_bank gpb_checker u_chk (.*);

// File: tb/gpb_port_bank_tb_top.sv
// port bank bench: register tests over classic wishbone
// board model on the pins, checker bound in
`timescale 1ns/100ps
module gpb_port_bank_tb_top;
  reg          sys_clk = 1'b0, reset_n = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  reg  [7:0]   wb_adr_i = 8'h00;
  reg  [31:0]  wb_dat_i = 32'h0, q;
  reg  [111:0] alt_claim = 112'h10000000000;
  reg  [1:0]   btn = 2'h1;
  wire [3:0]   wb_sel_i = 4'hF;
  wire [3:0]   lamp;
  wire [31:0]  wb_dat_o;
  wire [111:0] pin_in, pin_out, pin_oe;
  wire         wb_ack_o;
  integer      errors = 0, checks_done = 0, cycles = 0;
  always #10 sys_clk = ~sys_clk;
  gpb_port_bank u_dut (.*);
  gpb_board u_brd (.*);
  task summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] e, g);
    checks_done++;
    if (g !== e) begin errors++; $display("[ERR] %0t exp %h got %h", $time, e, g); end
  endtask
  task bus(input [7:0] a, input w, input [15:0] d);
    @(posedge sys_clk) {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 16'h0000, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task rd(input [7:0] a, input [15:0] e); bus(a, 1'b0, 16'h0000); chk(e, q); endtask
  always @(posedge sys_clk) if (++cycles > 500) begin errors++; summarize; end
  initial begin
    repeat (16) @(posedge sys_clk); reset_n <= 1'b1;
    rd(8'h00, 16'hFFFF); rd(8'h04, 16'h0000); rd(8'h0C, 16'h0000);
    $display("reset test done");
    bus(8'h10, 1'b1, 16'hC3FF); bus(8'h18, 1'b1, 16'h1400); rd(8'h14, 16'h1400);
    @(negedge sys_clk); chk(4'h5, lamp); rd(8'h18, 16'hD7FF); rd(8'h08, 16'hFF7F);
    $display("lamp and button test done");
    bus(8'h20, 1'b1, 16'h0000); bus(8'h2C, 1'b1, 16'hFFFF); bus(8'h24, 1'b1, 16'h00FF);
    @(negedge sys_clk); chk(16'hFE00, pin_oe[47:32]); rd(8'h28, 16'h01FF);
    bus(8'h70, 1'b1, 16'hFFFF); rd(8'h70, 16'h0000);
    $display("open drain test done");
    summarize;
  end
endmodule
